//--- logic/occ_pkg.sv
package occ_pkg;
   // Register byte offsets; oscillator and reference aliases sit at +4, +8, +c
   localparam logic [7:0] OFS_OSC = 8'h00;
   localparam logic [7:0] OFS_REF = 8'h20;
   localparam logic [7:0] OFS_KEY = 8'h40;
   localparam logic [1:0] AL_WR   = 2'h0;
   localparam logic [1:0] AL_CLR  = 2'h1;
   localparam logic [1:0] AL_SET  = 2'h2;
   localparam logic [1:0] AL_INV  = 2'h3;

   // Oscillator control field positions
   localparam int POS_PLL_OUT_DIV = 27;
   localparam int POS_FRC_DIV     = 24;
   localparam int POS_SOSC_RDY    = 22;
   localparam int POS_BUS_RDY     = 21;
   localparam int POS_BUS_DIV     = 19;
   localparam int POS_PLL_MULT    = 16;
   localparam int POS_CUR_OSC     = 12;
   localparam int POS_NEW_OSC     = 8;
   localparam int POS_SEL_LOCK    = 7;
   localparam int POS_USB_LOCK    = 6;
   localparam int POS_SYS_LOCK    = 5;
   localparam int POS_SLEEP       = 4;
   localparam int POS_SOSC_EN     = 1;
   localparam int POS_SWITCH      = 0;
   localparam logic [31:0] OSC_UNIMP = 32'hc080_8800;

   // Reference clock control field positions
   localparam int POS_REF_DIV   = 16;
   localparam int REF_DIV_W     = 15;
   localparam int POS_REF_ON    = 15;
   localparam int POS_DIV_SWEN  = 9;
   localparam int POS_REF_ACT   = 8;
   localparam int POS_REF_SRC   = 0;

   // Reset values
   localparam logic [2:0] RST_PLL_OUT_DIV = 3'h0;
   localparam logic [2:0] RST_FRC_DIV     = 3'h1;
   localparam logic [1:0] RST_BUS_DIV     = 2'h3;
   localparam logic [2:0] RST_PLL_MULT    = 3'h0;
   localparam logic [2:0] RST_OSC         = 3'h0;

   // Unlock keys, values arbitrary
   localparam logic [31:0] KEY_FIRST  = 32'h5a5a_1234;
   localparam logic [31:0] KEY_SECOND = 32'ha5a5_4321;

   // Divisor settling time after a bus divisor change
   localparam int CLK_MHZ      = 40;
   localparam int BUS_SETTLE_NS = 200;
   localparam int BUS_SETTLE_CYC =
      (BUS_SETTLE_NS * CLK_MHZ + 999) / 1000;

   // Fixed multiplier codes
   localparam logic [2:0] MULT_TOP_CODE = 3'h7;
   localparam logic [4:0] MULT_TOP      = 5'h18;
   localparam logic [4:0] MULT_BASE     = 5'h0f;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        we;
      logic        re;
   } occ_bus_req_type;

   typedef enum logic [1:0] {
      KEY_LOCKED = 2'b00,
      KEY_HALF   = 2'b01,
      KEY_OPEN   = 2'b10
   } occ_key_state_type;
endpackage

//--- logic/occ_clock_control.sv
`timescale 1ns/100ps
module occ_clock_control (
   input  wire logic                     clk_sys_i,
   input  wire logic                     rst_i,
   input  wire logic                     ce_i,
   input  wire occ_pkg::occ_bus_req_type bus_i,
   output logic [31:0]                   rdata_o,
   input  wire logic [2:0]               cfg_startup_osc_i,
   input  wire logic [1:0]               cfg_switch_monitor_i,
   input  wire logic                     sec_osc_running_i,
   input  wire logic                     sec_osc_stable_i,
   input  wire logic                     usb_pll_en_i,
   input  wire logic                     usb_pll_lock_i,
   input  wire logic                     usb_pll_timer_done_i,
   input  wire logic                     sys_pll_en_i,
   input  wire logic                     sys_pll_lock_i,
   input  wire logic                     sys_pll_timer_done_i,
   input  wire logic                     switch_done_i,
   input  wire logic                     wait_exec_i,
   output logic [8:0]                    pll_out_div_factor_o,
   output logic [8:0]                    fast_rc_div_factor_o,
   output logic [4:0]                    pll_mult_factor_o,
   output logic [2:0]                    cur_osc_sel_o,
   output logic [2:0]                    new_osc_sel_o,
   output logic                          osc_switch_req_o,
   output logic                          sec_osc_en_o,
   output logic                          periph_bus_clk_en_o,
   output logic                          sleep_req_o,
   output logic                          idle_req_o,
   output logic                          ref_on_o,
   output logic [3:0]                    ref_src_sel_o,
   output logic [14:0]                   ref_divider_o
);

   logic [2:0]  pll_out_div;
   logic [2:0]  fast_rc_div;
   logic [1:0]  bus_clk_divisor;
   logic [2:0]  pll_multiplier;
   logic [2:0]  cur_osc_sel;
   logic [2:0]  new_osc_sel;
   logic        clk_sel_lock;
   logic        sleep_on_wait;
   logic        sec_osc_en;
   logic        osc_switch_en;
   logic        bus_div_ready;
   logic [3:0]  settle_cnt;
   logic [2:0]  pb_cnt;
   logic        strap_done;
   logic        ref_on;
   logic        ref_div_switch_en;
   logic        ref_active;
   logic [3:0]  ref_src_sel;
   logic [14:0] ref_div_pend;
   logic [14:0] ref_divider;
   logic [31:0] osc_word;
   logic [31:0] ref_word;
   logic [31:0] osc_new;
   logic [31:0] ref_new;
   logic        sec_osc_ready;
   logic        usb_pll_locked;
   logic        sys_pll_locked;
   logic        sel_frozen;
   logic        osc_wr;
   logic        ref_wr;
   logic        key_wr;
   occ_pkg::occ_key_state_type key_state;

   // Power-of-two ladder with a jump to 256 at the top code
   function automatic logic [8:0] pow_div(input logic [2:0] code);
      pow_div = (code == 3'h7) ? 9'h100 : (9'h001 << code);
   endfunction

   // Bus clock counter wrap point: divide ratio minus one, 3 bits
   function automatic logic [2:0] pb_wrap(input logic [1:0] code);
      pb_wrap = 3'((4'h1 << code) - 4'h1);
   endfunction

   // Base, clear, set or invert view of one register
   function automatic logic [31:0] alias_apply(
      input logic [31:0] cur,
      input logic [31:0] wd,
      input logic [1:0]  sel);
      case (sel)
         occ_pkg::AL_CLR: alias_apply = cur & ~wd;
         occ_pkg::AL_SET: alias_apply = cur | wd;
         occ_pkg::AL_INV: alias_apply = cur ^ wd;
         default:         alias_apply = wd;
      endcase
   endfunction

   // Block match on the upper address nibble
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] base);
      hit = (a[7:4] == base[7:4]) && (a[1:0] == 2'h0);
   endfunction

   // Live status flags
   assign sec_osc_ready  = sec_osc_running_i & sec_osc_stable_i;
   assign usb_pll_locked = usb_pll_en_i &
      (usb_pll_lock_i | usb_pll_timer_done_i);
   assign sys_pll_locked = sys_pll_en_i &
      (sys_pll_lock_i | sys_pll_timer_done_i);
   assign sel_frozen = clk_sel_lock & cfg_switch_monitor_i[1];

   // Register images; unlisted bits stay zero
   always_comb begin
      osc_word = '0;
      osc_word[occ_pkg::POS_PLL_OUT_DIV +: 3] = pll_out_div;
      osc_word[occ_pkg::POS_FRC_DIV +: 3]     = fast_rc_div;
      osc_word[occ_pkg::POS_SOSC_RDY]         = sec_osc_ready;
      osc_word[occ_pkg::POS_BUS_RDY]          = bus_div_ready;
      osc_word[occ_pkg::POS_BUS_DIV +: 2]     = bus_clk_divisor;
      osc_word[occ_pkg::POS_PLL_MULT +: 3]    = pll_multiplier;
      osc_word[occ_pkg::POS_CUR_OSC +: 3]     = cur_osc_sel;
      osc_word[occ_pkg::POS_NEW_OSC +: 3]     = new_osc_sel;
      osc_word[occ_pkg::POS_SEL_LOCK]         = clk_sel_lock;
      osc_word[occ_pkg::POS_USB_LOCK]         = usb_pll_locked;
      osc_word[occ_pkg::POS_SYS_LOCK]         = sys_pll_locked;
      osc_word[occ_pkg::POS_SLEEP]            = sleep_on_wait;
      osc_word[occ_pkg::POS_SOSC_EN]          = sec_osc_en;
      osc_word[occ_pkg::POS_SWITCH]           = osc_switch_en;
      ref_word = '0;
      ref_word[occ_pkg::POS_REF_DIV +: occ_pkg::REF_DIV_W] = ref_div_pend;
      ref_word[occ_pkg::POS_REF_ON]   = ref_on;
      ref_word[occ_pkg::POS_DIV_SWEN] = ref_div_switch_en;
      ref_word[occ_pkg::POS_REF_ACT]  = ref_active;
      ref_word[occ_pkg::POS_REF_SRC +: 4] = ref_src_sel;
   end

   // Write decode, aliases folded in
   assign osc_new = alias_apply(osc_word, bus_i.wdata,
                                bus_i.addr[3:2]);
   assign ref_new = alias_apply(ref_word, bus_i.wdata,
                                bus_i.addr[3:2]);
   assign osc_wr = bus_i.we & hit(bus_i.addr, occ_pkg::OFS_OSC) &
                   (key_state == occ_pkg::KEY_OPEN) & strap_done;
   assign ref_wr = bus_i.we & hit(bus_i.addr, occ_pkg::OFS_REF);
   assign key_wr = bus_i.we & (bus_i.addr == occ_pkg::OFS_KEY);

   // Unlock: two keys in a row open, any other key write closes
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         key_state <= occ_pkg::KEY_LOCKED;
      end else if (ce_i && key_wr) begin
         case (key_state)
            occ_pkg::KEY_LOCKED: key_state <=
               (bus_i.wdata == occ_pkg::KEY_FIRST) ?
               occ_pkg::KEY_HALF : occ_pkg::KEY_LOCKED;
            occ_pkg::KEY_HALF: key_state <=
               (bus_i.wdata == occ_pkg::KEY_SECOND) ?
               occ_pkg::KEY_OPEN : occ_pkg::KEY_LOCKED;
            default: key_state <= occ_pkg::KEY_LOCKED;
         endcase
      end
   end

   // Startup strap is caught on the first enabled edge after release
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         strap_done <= 1'b0;
      end else if (ce_i) begin
         strap_done <= 1'b1;
      end
   end

   // Oscillator control fields
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pll_out_div    <= occ_pkg::RST_PLL_OUT_DIV;
         fast_rc_div    <= occ_pkg::RST_FRC_DIV;
         pll_multiplier <= occ_pkg::RST_PLL_MULT;
         new_osc_sel    <= occ_pkg::RST_OSC;
         clk_sel_lock   <= 1'b0;
         sleep_on_wait  <= 1'b0;
         sec_osc_en     <= 1'b0;
      end else if (ce_i) begin
         if (!strap_done) begin
            new_osc_sel <= cfg_startup_osc_i;
         end else if (osc_wr) begin
            fast_rc_div   <= osc_new[occ_pkg::POS_FRC_DIV +: 3];
            sleep_on_wait <= osc_new[occ_pkg::POS_SLEEP];
            sec_osc_en    <= osc_new[occ_pkg::POS_SOSC_EN];
            // Lock is one-way while the monitor config allows it
            if (!sel_frozen) begin
               pll_out_div    <= osc_new[occ_pkg::POS_PLL_OUT_DIV +: 3];
               pll_multiplier <= osc_new[occ_pkg::POS_PLL_MULT +: 3];
               new_osc_sel    <= osc_new[occ_pkg::POS_NEW_OSC +: 3];
               clk_sel_lock   <= osc_new[occ_pkg::POS_SEL_LOCK];
            end
         end
      end
   end

   // Switch request and completion; a software set beats the clear
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cur_osc_sel   <= occ_pkg::RST_OSC;
         osc_switch_en <= 1'b0;
      end else if (ce_i) begin
         if (!strap_done) begin
            cur_osc_sel <= cfg_startup_osc_i;
         end else begin
            if (osc_switch_en && switch_done_i) begin
               cur_osc_sel   <= new_osc_sel;
               osc_switch_en <= 1'b0;
            end
            if (osc_wr && !sel_frozen) begin
               osc_switch_en <= osc_new[occ_pkg::POS_SWITCH];
            end
         end
      end
   end

   // Bus divisor with settle window; ready low while it settles
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         bus_clk_divisor <= occ_pkg::RST_BUS_DIV;
         bus_div_ready   <= 1'b1;
         settle_cnt      <= 4'h0;
      end else if (ce_i) begin
         if (osc_wr && bus_div_ready) begin
            bus_clk_divisor <= osc_new[occ_pkg::POS_BUS_DIV +: 2];
            if (osc_new[occ_pkg::POS_BUS_DIV +: 2] != bus_clk_divisor) begin
               bus_div_ready <= 1'b0;
               settle_cnt <= 4'(occ_pkg::BUS_SETTLE_CYC - 1);
            end
         end else if (settle_cnt != 4'h0) begin
            settle_cnt <= settle_cnt - 4'h1;
         end else begin
            bus_div_ready <= 1'b1;
         end
      end
   end

   // Peripheral bus clock enable; wraps early if divisor shrinks
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pb_cnt <= 3'h0;
      end else if (ce_i) begin
         if (pb_cnt >= pb_wrap(bus_clk_divisor)) begin
            pb_cnt <= 3'h0;
         end else begin
            pb_cnt <= pb_cnt + 3'h1;
         end
      end
   end
   assign periph_bus_clk_en_o = ce_i &&
      (pb_cnt >= pb_wrap(bus_clk_divisor));

   // Reference clock control; divider held until switch enable while ref_on is set, loaded directly when off
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ref_on            <= 1'b0;
         ref_div_switch_en <= 1'b0;
         ref_active        <= 1'b0;
         ref_src_sel       <= 4'h0;
         ref_div_pend      <= 15'h0000;
         ref_divider       <= 15'h0000;
      end else if (ce_i) begin
         ref_active <= ref_on;
         if (ref_div_switch_en) begin
            ref_divider       <= ref_div_pend;
            ref_div_switch_en <= 1'b0;
         end
         if (ref_wr) begin
            ref_on      <= ref_new[occ_pkg::POS_REF_ON];
            ref_src_sel <= ref_new[occ_pkg::POS_REF_SRC +: 4];
            ref_div_pend <=
               ref_new[occ_pkg::POS_REF_DIV +: occ_pkg::REF_DIV_W];
            if (!ref_on) begin
               ref_divider <=
                  ref_new[occ_pkg::POS_REF_DIV +: occ_pkg::REF_DIV_W];
            end
            if (ref_new[occ_pkg::POS_DIV_SWEN]) begin
               ref_div_switch_en <= 1'b1;
            end
         end
      end
   end

   // Read port; unmapped offsets answer zero
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (ce_i && bus_i.re) begin
         if (hit(bus_i.addr, occ_pkg::OFS_OSC)) begin
            rdata_o <= osc_word;
         end else if (hit(bus_i.addr, occ_pkg::OFS_REF)) begin
            rdata_o <= ref_word;
         end else if (bus_i.addr == occ_pkg::OFS_KEY) begin
            rdata_o <= {31'h0, key_state == occ_pkg::KEY_OPEN};
         end else begin
            rdata_o <= 32'h0000_0000;
         end
      end
   end

   // Wait decode into low-power requests, one pulse each
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sleep_req_o <= 1'b0;
         idle_req_o  <= 1'b0;
      end else if (ce_i) begin
         sleep_req_o <= wait_exec_i & sleep_on_wait;
         idle_req_o  <= wait_exec_i & ~sleep_on_wait;
      end
   end

   // Decoded ratios registered for the analog side
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pll_out_div_factor_o <= 9'h001;
         fast_rc_div_factor_o <= 9'h002;
         pll_mult_factor_o    <= occ_pkg::MULT_BASE;
      end else if (ce_i) begin
         pll_out_div_factor_o <= pow_div(pll_out_div);
         fast_rc_div_factor_o <= pow_div(fast_rc_div);
         pll_mult_factor_o <= (pll_multiplier == occ_pkg::MULT_TOP_CODE) ?
            occ_pkg::MULT_TOP :
            occ_pkg::MULT_BASE + {2'h0, pll_multiplier};
      end
   end

   assign cur_osc_sel_o    = cur_osc_sel;
   assign new_osc_sel_o    = new_osc_sel;
   assign osc_switch_req_o = osc_switch_en;
   assign sec_osc_en_o     = sec_osc_en;
   assign ref_on_o         = ref_on;
   assign ref_src_sel_o    = ref_src_sel;
   assign ref_divider_o    = ref_divider;

   property p_unimp_zero;
      @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && bus_i.re && hit(bus_i.addr, occ_pkg::OFS_OSC)
      |=> (rdata_o & occ_pkg::OSC_UNIMP) == 32'h0;
   endproperty
   a_unimp_zero: assert property (p_unimp_zero)
      else $error("unimplemented oscillator bits read nonzero");

   property p_sosc_rdy;
      @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && bus_i.re && hit(bus_i.addr, occ_pkg::OFS_OSC)
      |=> rdata_o[occ_pkg::POS_SOSC_RDY] ==
          $past(sec_osc_running_i && sec_osc_stable_i);
   endproperty
   a_sosc_rdy: assert property (p_sosc_rdy)
      else $error("secondary ready flag wrong");

   property p_usb_lock;
      @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && bus_i.re && hit(bus_i.addr, occ_pkg::OFS_OSC)
      && !usb_pll_en_i |=> !rdata_o[occ_pkg::POS_USB_LOCK];
   endproperty
   a_usb_lock: assert property (p_usb_lock)
      else $error("usb pll lock shown while disabled");

   property p_div_blocked;
      @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && !bus_div_ready |=> $stable(bus_clk_divisor);
   endproperty
   a_div_blocked: assert property (p_div_blocked)
      else $error("bus divisor changed while not ready");

   property p_pb_half;
      @(posedge clk_sys_i) disable iff (rst_i)
      periph_bus_clk_en_o && bus_clk_divisor == 2'h1 ##1 ce_i
      |-> !periph_bus_clk_en_o ##1 (ce_i -> periph_bus_clk_en_o);
   endproperty
   a_pb_half: assert property (p_pb_half)
      else $error("bus clock enable not every second cycle");

   property p_locked_out;
      @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && strap_done && key_state != occ_pkg::KEY_OPEN
      |=> $stable(new_osc_sel) && $stable(sleep_on_wait);
   endproperty
   a_locked_out: assert property (p_locked_out)
      else $error("oscillator field changed without unlock");

   property p_frozen;
      @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && sel_frozen |=> $stable(pll_multiplier) && clk_sel_lock;
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("selection moved while locked");

   property p_switch_copy;
      @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && strap_done && osc_switch_en && switch_done_i
      |=> cur_osc_sel == $past(new_osc_sel);
   endproperty
   a_switch_copy: assert property (p_switch_copy)
      else $error("current oscillator not updated after switch");

   property p_sleep;
      @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && wait_exec_i |=>
      (sleep_req_o == $past(sleep_on_wait)) && (idle_req_o != sleep_req_o);
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("wait mapped to wrong low-power mode");

   property p_ref_hold;
      @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && ref_on && !ref_div_switch_en |=> $stable(ref_divider);
   endproperty
   a_ref_hold: assert property (p_ref_hold)
      else $error("reference divider applied without switch enable");

endmodule // occ_clock_control

//--- tb/occ_testbench.sv
`timescale 1ns/100ps
module testbench;
   logic                     clk_sys_i = 1'b0;
   logic                     rst_i = 1'b1;
   logic                     ce = 1'b1;
   occ_pkg::occ_bus_req_type bus_i = '0;
   logic [31:0]              rdata_o;
   logic [2:0]               cfg_startup_osc_i = 3'h5;
   logic [1:0]               cfg_switch_monitor_i = 2'h0;
   logic [7:0]               st = 8'h00;
   logic                     switch_done_i = 1'b0;
   logic                     wait_exec_i = 1'b0;
   logic [8:0]               pdiv, fdiv;
   logic [4:0]               mult;
   logic [2:0]               cur, nxt;
   logic                     sw, bus_en, slp, idl;
   logic [3:0]               src;
   logic [14:0]              rdiv;
   int                       errors = 0;
   int                       n_checks = 0;
   int                       dv[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
   int                       ml[8] = '{15, 16, 17, 18, 19, 20, 21, 24};
   localparam logic [7:0]    O = occ_pkg::OFS_OSC;
   localparam logic [7:0]    R = occ_pkg::OFS_REF;
   localparam logic [7:0]    K = occ_pkg::OFS_KEY;

   occ_clock_control dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
      .bus_i(bus_i), .rdata_o(rdata_o), .cfg_startup_osc_i(cfg_startup_osc_i),
      .cfg_switch_monitor_i(cfg_switch_monitor_i),
      .sec_osc_running_i(st[0]), .sec_osc_stable_i(st[1]),
      .usb_pll_en_i(st[2]), .usb_pll_lock_i(st[3]),
      .usb_pll_timer_done_i(st[4]), .sys_pll_en_i(st[5]),
      .sys_pll_lock_i(st[6]), .sys_pll_timer_done_i(st[7]),
      .switch_done_i(switch_done_i), .wait_exec_i(wait_exec_i),
      .pll_out_div_factor_o(pdiv), .fast_rc_div_factor_o(fdiv),
      .pll_mult_factor_o(mult), .cur_osc_sel_o(cur), .new_osc_sel_o(nxt),
      .osc_switch_req_o(sw), .sec_osc_en_o(), .periph_bus_clk_en_o(bus_en),
      .sleep_req_o(slp), .idle_req_o(idl), .ref_on_o(), .ref_src_sel_o(src),
      .ref_divider_o(rdiv));

   // Free-running system clock, 25 ns period
   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   // Write strobe lasts one cycle; register fields settle before return, ratio outputs one edge later
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i) bus_i <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys_i) bus_i.we <= 1'b0;
      #1;
   endtask

   // Read data is registered on the strobe edge and holds until the next read
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys_i) bus_i <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk_sys_i) bus_i.re <= 1'b0;
      #1 v = rdata_o;
   endtask

   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   // Bus clock enable pulses over 16 system cycles
   task automatic cnt(input int e);
      int n;
      n = 0;
      repeat (16) begin
         @(posedge clk_sys_i) #1 n += int'(bus_en);
      end
      chk(32'(e), 32'(n));
   endtask

   task automatic wex(input logic s);
      @(posedge clk_sys_i) wait_exec_i <= 1'b1;
      @(posedge clk_sys_i) wait_exec_i <= 1'b0;
      #1 chk({31'h0, s}, {31'h0, slp});
      chk({31'h0, !s}, {31'h0, idl});
   endtask

   task automatic conclude();
      $display("errors=%0d n_checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Whole run is under two thousand cycles; cut a hang well beyond that
   initial begin
      #2000000;
      errors++;
      conclude();
   end

   initial begin
      logic [31:0] v;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rd(O, v);
      chk(32'h0138_5500, v);
      chk(32'd2, 32'(fdiv));
      chk(32'd15, 32'(mult));
      cnt(2);
      // Enable low freezes all; a landed key would spoil the unlock below
      @(posedge clk_sys_i) ce <= 1'b0;
      cnt(0);
      wr(K, occ_pkg::KEY_FIRST);
      @(posedge clk_sys_i) ce <= 1'b1;
      // Writes before the key pair must not land
      wr(O + 8'h08, 32'h10);
      rd(O, v);
      chk(32'h0, v & 32'h10);
      wr(K, occ_pkg::KEY_FIRST);
      wr(K, occ_pkg::KEY_SECOND);
      for (int k = 0; k < 8; k++) begin
         wr(O + 8'h04, 32'h3f07_0000);
         wr(O + 8'h08, (32'(k) << 27) | (32'(k) << 24) | (32'(k) << 16));
         // Ratio outputs are registered one edge behind the fields
         @(posedge clk_sys_i) #1 chk(32'(dv[k]), 32'(pdiv));
         chk(32'(dv[k]), 32'(fdiv));
         chk(32'(ml[k]), 32'(mult));
      end
      wr(O + 8'h0c, occ_pkg::OSC_UNIMP);
      rd(O, v);
      chk(32'h0, v & occ_pkg::OSC_UNIMP);
      wr(O + 8'h08, 32'h10);
      wex(1'b1);
      wr(O + 8'h04, 32'h10);
      wex(1'b0);
      wr(O + 8'h0c, 32'h10);
      rd(O, v);
      chk(32'h10, v & 32'h10);
      // Every combination of oscillator and PLL status inputs
      for (int i = 0; i < 256; i++) begin
         @(posedge clk_sys_i) st <= 8'(i);
         repeat (3) @(posedge clk_sys_i);
         rd(O, v);
         chk({9'h0, st[0] & st[1], 22'h0}, v & 32'h0040_0000);
         chk({25'h0, st[2] & (st[3] | st[4]), 6'h0}, v & 32'h40);
         chk({26'h0, st[5] & (st[6] | st[7]), 5'h0}, v & 32'h20);
      end
      // Second divisor write is dropped while ready is still low
      wr(O + 8'h04, 32'h0018_0000);
      wr(O + 8'h08, 32'h0008_0000);
      rd(O, v);
      chk(32'h0, v & 32'h0038_0000);
      repeat (10) @(posedge clk_sys_i);
      rd(O, v);
      chk(32'h0020_0000, v & 32'h0038_0000);
      wr(O + 8'h08, 32'h0008_0000);
      repeat (10) @(posedge clk_sys_i);
      cnt(8);
      wr(O + 8'h04, 32'h700);
      wr(O + 8'h08, 32'h301);
      chk(32'h3, 32'(nxt));
      chk(32'h1, 32'(sw));
      @(posedge clk_sys_i) switch_done_i <= 1'b1;
      @(posedge clk_sys_i) switch_done_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1 chk(32'h3, 32'(cur));
      chk(32'h0, 32'(sw));
      // Lock bit is inert until the monitor config says 1x
      wr(O + 8'h08, 32'h80);
      wr(O + 8'h04, 32'h700);
      chk(32'h0, 32'(nxt));
      @(posedge clk_sys_i) cfg_switch_monitor_i <= 2'h2;
      wr(O + 8'h08, 32'h500);
      chk(32'h0, 32'(nxt));
      for (int s = 0; s < 16; s++) begin
         wr(R, 32'h0005_0000 | 32'(s));
         chk(32'(s), 32'(src));
      end
      chk(32'h5, 32'(rdiv));
      wr(R + 8'h08, 32'h8000);
      wr(R, 32'h0009_8008);
      chk(32'h5, 32'(rdiv));
      wr(R + 8'h08, 32'h200);
      @(posedge clk_sys_i) #1 chk(32'h9, 32'(rdiv));
      rd(8'h60, v);
      chk(32'h0, v);
      conclude();
   end
endmodule // testbench
